// ==== rtl/sensor_regs.svh ====
// command codes, status bit positions, reset values and crc constants
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH

`define CMD_HEAT_ON       16'h306D
`define CMD_HEAT_OFF      16'h3066
`define CMD_CLR_STAT      16'h3041
`define CMD_SOFT_RST      16'h30A2
`define CMD_RD_STAT       16'hF32D
`define CMD_FETCH         16'hE000
`define GC_RESET_BYTE     8'h06
`define GC_ADDR           7'h00
`define DEV_ADDR_DEFAULT  7'h45

`define ST_ALERT          4'hF
`define ST_HEATER         4'hD
`define ST_RH_ALERT       4'hB
`define ST_T_ALERT        4'hA
`define ST_RESET_SEEN     4'h4
`define ST_CMD_FAIL       4'h1
`define ST_WR_CRC_FAIL    4'h0
`define STATUS_RESET      16'h8010
`define STATUS_MASK       16'hAC13

`define CRC_POLY          8'h31
`define CRC_INIT          8'hFF
`define CRC_XOROUT        8'h00
`define IDLE_BYTE         8'hFF
`define WR_BUF_BYTES      3'h5

`endif

// ==== rtl/sensor_pkg.sv ====
// shared types of the sensor command block
package sensor_pkg;

	typedef struct packed {
		logic scl;
		logic sda;
	} line_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RX   = 2'b01,
		ST_TX   = 2'b10
	} link_state_type;

	typedef enum logic [1:0] {
		SRC_NONE   = 2'b00,
		SRC_STATUS = 2'b01,
		SRC_MEAS   = 2'b10
	} source_type;

endpackage : sensor_pkg

// ==== rtl/sensor_status_heater_crc.sv ====
// two-wire slave with heater, status word and crc-protected words
`include "sensor_regs.svh"
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - heater on 0x306D, off 0x3066
// - heater stays off after any reset
// - status bit 13 mirrors heater state
// - status word holds heater, alert, command outcomes
// - bit 15 set while alerts pending, resets one
// - bit 4 set on resets until cleared
// - bit 1 flags last command not processed
// - bit 0 flags bad write data checksum
// - clear command 0x3041 zeroes bits 15,11,10,4
// - every data word followed by its crc
// - crc poly 0x31, init 0xFF, no reflection
// - measurements sent as unsigned raw words, temperature first
module sensor_status_heater_crc #(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// two-wire link
	input  wire logic        i_scl,
	input  wire logic        i_sda_in,
	output var  logic        o_sda_out,
	output var  logic        o_sda_oe,
	// sensor core side
	input  wire logic        i_rh_alert,
	input  wire logic        i_t_alert,
	input  wire logic        i_supply_fail,
	input  wire logic [15:0] i_raw_humidity_word,
	input  wire logic [15:0] i_raw_temp_word,
	// state
	output var  logic        o_heater_on,
	output var  logic [15:0] o_status_word
);

	function automatic logic [7:0] crc8(input logic [15:0] word);
		logic [7:0] c;
		c = `CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ word[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
		end
		return c ^ `CRC_XOROUT;
	endfunction : crc8

	function automatic logic [7:0] tx_byte(input sensor_pkg::source_type src,
		input logic [2:0] idx, input logic [15:0] wa, input logic [15:0] wb);
		logic [7:0] b;
		b = `IDLE_BYTE;
		if (src != sensor_pkg::SRC_NONE) begin
			case (idx)
				3'h0: b = wa[15:8];
				3'h1: b = wa[7:0];
				3'h2: b = crc8(wa);
				3'h3: b = (src == sensor_pkg::SRC_MEAS) ? wb[15:8] : `IDLE_BYTE;
				3'h4: b = (src == sensor_pkg::SRC_MEAS) ? wb[7:0] : `IDLE_BYTE;
				3'h5: b = (src == sensor_pkg::SRC_MEAS) ? crc8(wb) : `IDLE_BYTE;
				default: b = `IDLE_BYTE;
			endcase
		end
		return b;
	endfunction : tx_byte

	sensor_pkg::line_type       line_s1_r, line_s2_r, line_s3_r, line_f_r, line_d_r;
	sensor_pkg::link_state_type state_r;
	sensor_pkg::source_type     src_r;
	logic                       is_addr_r;
	logic                       gc_r;
	logic                       wr_act_r;
	logic [3:0]                 bit_cnt_r;
	logic [7:0]                 shift_r;
	logic [7:0]                 tx_r;
	logic [2:0]                 wr_cnt_r;
	logic [2:0]                 rd_idx_r;
	logic [7:0]                 wr_buf_r [0:4];
	logic                       sda_oe_r;
	logic                       sda_out_r;
	logic [15:0]                word_a_r, word_b_r;
	logic [15:0]                stat_r, stat_nxt;
	logic                       heater_r, heater_nxt;

	// three-stage sampling; a change counts once stages two and three agree
	always_ff @(posedge i_clock) begin
		line_s1_r <= '{scl: i_scl, sda: i_sda_in};
		line_s2_r <= line_s1_r;
		line_s3_r <= line_s2_r;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			line_f_r <= '{scl: 1'b1, sda: 1'b1};
			line_d_r <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			if (line_s2_r.scl == line_s3_r.scl)
				line_f_r.scl <= line_s3_r.scl;
			if (line_s2_r.sda == line_s3_r.sda)
				line_f_r.sda <= line_s3_r.sda;
			line_d_r <= line_f_r;
		end
	end

	wire scl_rise  = line_f_r.scl & ~line_d_r.scl;
	wire scl_fall  = ~line_f_r.scl & line_d_r.scl;
	wire scl_held  = line_f_r.scl & line_d_r.scl;
	wire cond_start = scl_held & line_d_r.sda & ~line_f_r.sda;
	wire cond_stop  = scl_held & ~line_d_r.sda & line_f_r.sda;
	wire frame_end  = cond_start | cond_stop;

	wire [15:0] cmd_word   = {wr_buf_r[0], wr_buf_r[1]};
	wire        is_heat_on = cmd_word == `CMD_HEAT_ON;
	wire        is_heat_off = cmd_word == `CMD_HEAT_OFF;
	wire        is_clear   = cmd_word == `CMD_CLR_STAT;
	wire        is_srst    = cmd_word == `CMD_SOFT_RST;
	wire        is_rd_stat = cmd_word == `CMD_RD_STAT;
	wire        is_fetch   = cmd_word == `CMD_FETCH;
	wire        cmd_known  = is_heat_on | is_heat_off | is_clear | is_srst | is_rd_stat | is_fetch;
	wire        exec       = frame_end & wr_act_r & ~gc_r & (wr_cnt_r >= 3'h2);
	wire        gc_exec    = frame_end & wr_act_r & gc_r & (wr_cnt_r != 3'h0)
		& (wr_buf_r[0] == `GC_RESET_BYTE);
	wire        has_data   = wr_cnt_r == `WR_BUF_BYTES;
	wire        data_bad   = crc8({wr_buf_r[2], wr_buf_r[3]}) != wr_buf_r[4];
	wire        addr_gc    = (shift_r[7:1] == `GC_ADDR) & ~shift_r[0];
	wire        addr_hit   = (shift_r[7:1] == DEV_ADDR) | addr_gc;
	wire [2:0]  tx_idx     = (state_r == sensor_pkg::ST_RX) ? 3'h0 : rd_idx_r;
	wire [7:0]  tx_next    = tx_byte(src_r, tx_idx, word_a_r, word_b_r);
	wire        tx_bit     = tx_r[3'h7 - bit_cnt_r[2:0]];

	// byte engine: ack slot is count 8, count 9 hands over to the next byte
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r   <= sensor_pkg::ST_IDLE;
			is_addr_r <= 1'b0;
			gc_r      <= 1'b0;
			wr_act_r  <= 1'b0;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			tx_r      <= 8'h00;
			wr_cnt_r  <= 3'h0;
			rd_idx_r  <= 3'h0;
			sda_oe_r  <= 1'b0;
		end else if (frame_end) begin
			state_r   <= cond_start ? sensor_pkg::ST_RX : sensor_pkg::ST_IDLE;
			is_addr_r <= 1'b1;
			wr_act_r  <= 1'b0;
			bit_cnt_r <= 4'h0;
			rd_idx_r  <= 3'h0;
			sda_oe_r  <= 1'b0;
		end else begin
			case (state_r)
				sensor_pkg::ST_RX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (bit_cnt_r < 4'h8)
							shift_r <= {shift_r[6:0], line_f_r.sda};
					end
					if (scl_fall && bit_cnt_r == 4'h8) begin
						if (is_addr_r && !addr_hit) begin
							state_r <= sensor_pkg::ST_IDLE;
						end else begin
							sda_oe_r <= 1'b1;
							if (is_addr_r) begin
								gc_r     <= addr_gc;
								wr_act_r <= ~shift_r[0];
								wr_cnt_r <= 3'h0;
							end else if (wr_cnt_r != `WR_BUF_BYTES) begin
								wr_buf_r[wr_cnt_r] <= shift_r;
								wr_cnt_r <= wr_cnt_r + 3'h1;
							end
						end
					end
					if (scl_fall && bit_cnt_r == 4'h9) begin
						bit_cnt_r <= 4'h0;
						is_addr_r <= 1'b0;
						sda_oe_r  <= 1'b0;
						if (is_addr_r && shift_r[0]) begin
							state_r  <= sensor_pkg::ST_TX;
							tx_r     <= tx_next;
							sda_oe_r <= ~tx_next[7];
							rd_idx_r <= 3'h1;
						end
					end
				end
				sensor_pkg::ST_TX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						// a nack ends the read; the master follows with stop
						if (bit_cnt_r == 4'h8 && line_f_r.sda)
							state_r <= sensor_pkg::ST_IDLE;
					end
					if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe_r <= 1'b0;
						end else if (bit_cnt_r == 4'h9) begin
							bit_cnt_r <= 4'h0;
							tx_r      <= tx_next;
							sda_oe_r  <= ~tx_next[7];
							if (rd_idx_r != 3'h7)
								rd_idx_r <= rd_idx_r + 3'h1;
						end else if (bit_cnt_r != 4'h0) begin
							sda_oe_r <= ~tx_bit;
						end
					end
				end
				default: begin
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// open drain: the line is only ever pulled low
	always_ff @(posedge i_clock) begin
		sda_out_r <= 1'b0;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			src_r    <= sensor_pkg::SRC_NONE;
			word_a_r <= 16'h0000;
			word_b_r <= 16'h0000;
		end else if (exec) begin
			src_r <= sensor_pkg::SRC_NONE;
			if (is_rd_stat) begin
				src_r    <= sensor_pkg::SRC_STATUS;
				word_a_r <= stat_r;
			end
			if (is_fetch) begin
				src_r    <= sensor_pkg::SRC_MEAS;
				word_a_r <= i_raw_temp_word;
				word_b_r <= i_raw_humidity_word;
			end
		end
	end

	always_comb begin
		stat_nxt   = stat_r;
		heater_nxt = heater_r;
		if (exec) begin
			stat_nxt[`ST_CMD_FAIL] = ~cmd_known;
			if (has_data)
				stat_nxt[`ST_WR_CRC_FAIL] = data_bad;
			if (is_clear) begin
				stat_nxt[`ST_ALERT]      = 1'b0;
				stat_nxt[`ST_RH_ALERT]   = 1'b0;
				stat_nxt[`ST_T_ALERT]    = 1'b0;
				stat_nxt[`ST_RESET_SEEN] = 1'b0;
			end
			if (is_heat_on)
				heater_nxt = 1'b1;
			if (is_heat_off || is_srst)
				heater_nxt = 1'b0;
		end
		if ((exec && is_srst) || gc_exec) begin
			stat_nxt[`ST_RESET_SEEN] = 1'b1;
			heater_nxt = 1'b0;
		end
		// events win over a clear in the same cycle
		if (i_rh_alert) begin
			stat_nxt[`ST_RH_ALERT] = 1'b1;
			stat_nxt[`ST_ALERT]    = 1'b1;
		end
		if (i_t_alert) begin
			stat_nxt[`ST_T_ALERT] = 1'b1;
			stat_nxt[`ST_ALERT]   = 1'b1;
		end
		if (i_supply_fail)
			stat_nxt[`ST_RESET_SEEN] = 1'b1;
		stat_nxt[`ST_HEATER] = heater_nxt;
		stat_nxt = stat_nxt & `STATUS_MASK;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			stat_r   <= `STATUS_RESET;
			heater_r <= 1'b0;
		end else begin
			stat_r   <= stat_nxt;
			heater_r <= heater_nxt;
		end
	end

	assign o_sda_out     = sda_out_r;
	assign o_sda_oe      = sda_oe_r;
	assign o_heater_on   = heater_r;
	assign o_status_word = stat_r;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence s_heat_on;
		exec && is_heat_on && !is_heat_off;
	endsequence
	sequence s_clear_quiet;
		exec && is_clear && !i_rh_alert && !i_t_alert && !i_supply_fail;
	endsequence

	a_heater_enable: assert property (s_heat_on |=> o_heater_on && o_status_word[13])
		else $error("heater enable not applied");
	a_heater_disable: assert property (exec && is_heat_off |=> !o_heater_on)
		else $error("heater disable not applied");
	a_heater_reset: assert property ($fell(i_rst) |-> !o_heater_on && o_status_word == 16'h8010)
		else $error("bad state after reset");
	a_heater_mirror: assert property (o_status_word[13] == o_heater_on)
		else $error("status bit 13 differs from heater");
	a_alert_sets: assert property (i_rh_alert |=> o_status_word[15] && o_status_word[11])
		else $error("alert event lost");
	a_clear_flags: assert property (s_clear_quiet |=> (o_status_word & 16'h8C10) == 16'h0000)
		else $error("clear status left flags set");
	a_reset_seen: assert property ((exec && is_srst) || gc_exec |=> o_status_word[4] && !o_heater_on)
		else $error("soft reset not recorded");
	a_cmd_outcome: assert property (exec |=> o_status_word[1] == !$past(cmd_known))
		else $error("command status wrong");
	a_write_crc: assert property (exec && has_data |=> o_status_word[0] == $past(data_bad))
		else $error("write checksum status wrong");
	a_crc_vector: assert property (crc8(16'hBEEF) == 8'h92)
		else $error("crc engine wrong");
	a_status_first: assert property (exec && is_rd_stat |=> src_r == sensor_pkg::SRC_STATUS
		&& word_a_r == $past(stat_r))
		else $error("status snapshot wrong");

endmodule : sensor_status_heater_crc

`default_nettype wire

// ==== testbench/host_master.sv ====
// behavioural two-wire bus master standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module host_master (
	// bus lines, data is open drain
	output var  logic o_scl,
	output var  logic o_sda_oe,
	input  wire logic i_sda
);
	// clock stands high between frames
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic start;
		o_sda_oe = 1'b0;
		#31.25 o_scl = 1'b1;
		#31.25 o_sda_oe = 1'b1;
		#31.25 o_scl = 1'b0;
	endtask : start
	task automatic stop;
		#31.25 o_sda_oe = 1'b1;
		#31.25 o_scl = 1'b1;
		#31.25 o_sda_oe = 1'b0;
		#31.25;
	endtask : stop
	// data moves mid-low so setup before the rise is wide
	task automatic send_bit(input logic b);
		#31.25 o_sda_oe = ~b;
		#31.25 o_scl = 1'b1;
		#62.5 o_scl = 1'b0;
	endtask : send_bit
	task automatic take_bit(output logic b);
		#31.25 o_sda_oe = 1'b0;
		#31.25 o_scl = 1'b1;
		#31.25 b = i_sda;
		#31.25 o_scl = 1'b0;
	endtask : take_bit
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) send_bit(d[i]);
		take_bit(a);
		ack = ~a;
	endtask : put_byte
	// word bytes then crc, nack ends the read
	task automatic get_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) take_bit(d[i]);
		send_bit(last);
	endtask : get_byte
endmodule : host_master
`default_nettype wire

// ==== testbench/test_sensor_status_heater_crc.sv ====
// self-checking bench of the sensor command block
`include "sensor_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module test_sensor_status_heater_crc;
	logic        i_clock, i_rst, rh, ta, sf, ack;
	logic [15:0] hum, tmp, exp_st, w;
	logic [7:0]  rx [6];
	wire  logic  scl, host_oe, dut_oe, sda_out, heat;
	wire  logic [15:0] st;
	// pull-up: low while the host pulls or the device enables a low level
	wire  logic  sda = ~host_oe & (dut_oe ? sda_out : 1'b1);
	int          error_cnt, n_compared, cyc;

	host_master host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));
	sensor_status_heater_crc dut (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl),
		.i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(dut_oe), .i_rh_alert(rh),
		.i_t_alert(ta), .i_supply_fail(sf), .i_raw_humidity_word(hum),
		.i_raw_temp_word(tmp), .o_heater_on(heat), .o_status_word(st));

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			wrap_up();
		end
	end

	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		return c;
	endfunction : crc8
	// host scaling of a raw humidity word, whole percent
	function automatic logic [15:0] rh_pct(input logic [15:0] raw);
		return 16'((32'h64 * {16'h0, raw}) / 32'hFFFF);
	endfunction : rh_pct
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : check
	task automatic wr(input logic [15:0] cmd, input int n, input logic [23:0] ext);
		host.start();
		host.put_byte(8'h8A, ack);
		check("address ack", 16'h0001, {15'h0, ack});
		host.put_byte(cmd[15:8], ack);
		host.put_byte(cmd[7:0], ack);
		for (int i = 2; i >= 0 && n == 5; i--) host.put_byte(ext[i*8+:8], ack);
		host.stop();
		repeat (10) @(posedge i_clock);
	endtask : wr
	task automatic rd(input int n);
		host.start();
		host.put_byte(8'h8B, ack);
		for (int i = 0; i < n; i++) host.get_byte(i == n - 1, rx[i]);
		host.stop();
	endtask : rd
	task automatic pulse(input int k);
		@(posedge i_clock);
		{rh, ta, sf} <= 3'b100 >> k;
		@(posedge i_clock);
		{rh, ta, sf} <= 3'b000;
		repeat (2) @(posedge i_clock);
	endtask : pulse
	task automatic wrap_up;
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		{i_rst, rh, ta, sf} = 4'hF ^ 4'h7;
		{hum, tmp} = 32'h0;
		void'($urandom(32235));
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_clock);
		exp_st = 16'h8010;
		check("status after reset", exp_st, st);
		check("heater after reset", 16'h0, {15'h0, heat});
		wr(`CMD_HEAT_ON, 2, 24'h0);
		exp_st[13] = 1'b1;
		check("heater on", 16'h0001, {15'h0, heat});
		check("status heater bit", exp_st, st);
		wr(`CMD_RD_STAT, 2, 24'h0);
		rd(3);
		check("status read word", exp_st, {rx[0], rx[1]});
		check("status read crc", {8'h0, crc8(exp_st)}, {8'h0, rx[2]});
		wr(`CMD_HEAT_OFF, 2, 24'h0);
		exp_st[13] = 1'b0;
		check("heater off", exp_st, st);
		// unknown msb keeps random codes outside the valid set
		wr({8'h5A, 8'($urandom)}, 2, 24'h0);
		check("invalid command", exp_st | 16'h0002, st);
		wr(`CMD_CLR_STAT, 2, 24'h0);
		exp_st = 16'h0000;
		check("cleared", exp_st, st);
		for (int k = 0; k < 3; k++) pulse(k);
		check("alert flags", 16'h8C10, st);
		wr(`CMD_CLR_STAT, 2, 24'h0);
		check("clear flags", exp_st, st);
		w = 16'($urandom);
		wr(`CMD_HEAT_OFF, 5, {w, crc8(w) ^ 8'h01});
		check("bad write crc", 16'h0001, st);
		wr(`CMD_HEAT_OFF, 5, {w, crc8(w)});
		check("good write crc", exp_st, st);
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clock);
			tmp <= (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'($urandom);
			hum <= (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
			@(posedge i_clock);
			wr(`CMD_FETCH, 2, 24'h0);
			rd(6);
			check("temp word", tmp, {rx[0], rx[1]});
			check("temp crc", {8'h0, crc8(tmp)}, {8'h0, rx[2]});
			check("hum word", hum, {rx[3], rx[4]});
			check("hum crc", {8'h0, crc8(hum)}, {8'h0, rx[5]});
			if (k < 2) check("hum scale", (k == 0) ? 16'h0064 : 16'h0000, rh_pct({rx[3], rx[4]}));
		end
		wr(`CMD_HEAT_ON, 2, 24'h0);
		wr(`CMD_SOFT_RST, 2, 24'h0);
		check("soft reset status", 16'h0010, st);
		wr(`CMD_CLR_STAT, 2, 24'h0);
		wr(`CMD_HEAT_ON, 2, 24'h0);
		// general call: broadcast address, then the reset byte
		host.start();
		host.put_byte(8'h00, ack);
		check("general call ack", 16'h0001, {15'h0, ack});
		host.put_byte(`GC_RESET_BYTE, ack);
		host.stop();
		repeat (10) @(posedge i_clock);
		check("general call status", 16'h0010, st);
		// mid-run reset with the heater on
		wr(`CMD_HEAT_ON, 2, 24'h0);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_clock);
		check("status after mid reset", 16'h8010, st);
		check("heater after mid reset", 16'h0, {15'h0, heat});
		rd(1);
		check("read with nothing selected", 16'h00FF, {8'h0, rx[0]});
		host.start();
		host.put_byte(8'h8C, ack);
		check("foreign address ack", 16'h0, {15'h0, ack});
		host.stop();
		wrap_up();
	end
endmodule : test_sensor_status_heater_crc
`default_nettype wire
